// file: src/otg_evt_pkg.sv
// constants shared by the event interrupt register block
package otg_evt_pkg;

	// ========================================================
	// widths
	localparam int unsigned SRC_W  = 5;
	localparam int unsigned REG_W  = 8;
	localparam int unsigned IDX_W  = 30;

	// ========================================================
	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_RISE_WR   = 30'h0000000D;
	localparam logic [IDX_W-1:0] IDX_RISE_SET  = 30'h0000000E;
	localparam logic [IDX_W-1:0] IDX_RISE_CLR  = 30'h0000000F;
	localparam logic [IDX_W-1:0] IDX_FALL_WR   = 30'h00000010;
	localparam logic [IDX_W-1:0] IDX_FALL_SET  = 30'h00000011;
	localparam logic [IDX_W-1:0] IDX_FALL_CLR  = 30'h00000012;
	localparam logic [IDX_W-1:0] IDX_LIVE      = 30'h00000013;
	localparam logic [IDX_W-1:0] IDX_LATCH     = 30'h00000014;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT  = 30'h00000020;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK  = 30'h00000021;

	// ========================================================
	// source bit positions, shared by every register of the block
	localparam int unsigned BIT_ID_GROUNDED     = 4;
	localparam int unsigned BIT_SESS_OVER  = 3;
	localparam int unsigned BIT_SESS_OK    = 2;
	localparam int unsigned BIT_PWR_OK     = 1;
	localparam int unsigned BIT_DETACH     = 0;

	// ========================================================
	// reset values
	localparam logic [SRC_W-1:0] RST_EDGE_EN   = 5'h1F;
	localparam logic [SRC_W-1:0] RST_LATCH     = 5'h00;
	localparam logic [SRC_W-1:0] RST_IRQ_STAT  = 5'h00;
	localparam logic [SRC_W-1:0] RST_IRQ_MASK  = 5'h00;

	// ========================================================
	// bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage

// file: src/src_edge_detect.sv
// per-source sampling and edge detection for the event sources
`timescale 1ns/1ps
`default_nettype none

module src_edge_detect
	import otg_evt_pkg::*;
(
	input  wire logic             sys_clk,   // system clock
	input  wire logic             sys_rst,   // synchronous reset, active high
	input  wire logic [SRC_W-1:0] src_in,    // raw source levels
	output logic      [SRC_W-1:0] src_now,   // sampled source levels
	output logic      [SRC_W-1:0] rise,      // 0 to 1 seen this cycle
	output logic      [SRC_W-1:0] fall       // 1 to 0 seen this cycle
);

	// ========================================================
	// sampling
	logic [SRC_W-1:0] cur_ff;
	logic [SRC_W-1:0] prv_ff;
	logic             armed_ff;
	logic [SRC_W-1:0] nxt_cur;
	logic [SRC_W-1:0] nxt_prv;
	logic             nxt_armed;

	always_comb
	begin
		nxt_cur   = src_in;
		// the first sample after reset primes both stages, so a source
		// that is already high at release does not look like a rise
		nxt_prv   = armed_ff ? cur_ff : src_in;
		nxt_armed = 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			cur_ff   <= 5'h00;
			prv_ff   <= 5'h00;
			armed_ff <= 1'b0;
		end
		else
		begin
			cur_ff   <= nxt_cur;
			prv_ff   <= nxt_prv;
			armed_ff <= nxt_armed;
		end
	end

	assign src_now = cur_ff;

	// ========================================================
	// edges: compare each sample with the previous clock's one
	// armed waits one sample so reset values never fake an edge
	genvar g;
	generate
		for (g = 0; g < SRC_W; g++)
		begin : g_bit
			assign rise[g] = armed_ff & cur_ff[g] & ~prv_ff[g];
			assign fall[g] = armed_ff & ~cur_ff[g] & prv_ff[g];
		end
	endgenerate

endmodule

`default_nettype wire

// file: src/usb_otg_event_interrupt_regs.sv
// event interrupt registers of the otg transceiver, reached over ahb-lite
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module usb_otg_event_interrupt_regs
	import otg_evt_pkg::*;
(
	input  wire logic             sys_clk,       // system clock, 50 MHz
	input  wire logic             sys_rst,       // synchronous reset, active high
	input  wire logic             hsel,          // slave select
	input  wire logic [31:0]      haddr,         // byte address
	input  wire logic [1:0]       htrans,        // transfer type
	input  wire logic             hwrite,        // write when high
	input  wire logic [2:0]       hsize,         // transfer size
	input  wire logic [31:0]      hwdata,        // write data
	input  wire logic             hready,        // bus ready
	output logic      [31:0]      hrdata,        // read data
	output logic                  hreadyout,     // slave ready
	output logic                  hresp,         // always okay
	input  wire logic             id_grounded,   // id detector
	input  wire logic             session_over,  // session end comparator
	input  wire logic             session_ok,    // session valid comparator
	input  wire logic             bus_power_ok,  // bus_power_ok_bit comparator
	input  wire logic             host_detach,   // host disconnect detector
	input  wire logic             low_power_enter, // pulse: phy enters low power
	output logic                  rxcmd_valid,   // rxcmd waiting for the link
	output logic      [SRC_W-1:0] rxcmd_data,    // source values carried
	input  wire logic             rxcmd_ready,   // link takes the rxcmd
	output logic                  irq            // level interrupt
);

	// ========================================================
	// sources and edges
	logic [SRC_W-1:0] src_raw;
	logic [SRC_W-1:0] src_now;
	logic [SRC_W-1:0] rise;
	logic [SRC_W-1:0] fall;

	always_comb
	begin
		src_raw                = 5'h00;
		src_raw[BIT_ID_GROUNDED]    = id_grounded;
		src_raw[BIT_SESS_OVER] = session_over;
		src_raw[BIT_SESS_OK]   = session_ok;
		src_raw[BIT_PWR_OK]    = bus_power_ok;
		src_raw[BIT_DETACH]    = host_detach;
	end

	src_edge_detect u_edge
	(
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.src_in  (src_raw),
		.src_now (src_now),
		.rise    (rise),
		.fall    (fall)
	);

	// ========================================================
	// bus front end
	// reads take one wait state so that a write in the preceding data
	// phase is already visible; writes finish with no wait
	logic             wr_pend_ff;
	logic             rd_pend_ff;
	logic [IDX_W-1:0] idx_ff;
	logic             hreadyout_ff;
	logic [31:0]      hrdata_ff;
	logic             nxt_wr_pend;
	logic             nxt_rd_pend;
	logic [IDX_W-1:0] nxt_idx;
	logic             nxt_hreadyout;
	logic [31:0]      nxt_hrdata;
	logic             take;
	logic [REG_W-1:0] wbyte;
	logic             wr_do;
	logic             rd_do;

	assign take  = hsel & hready & htrans[1];
	assign wbyte = hwdata[REG_W-1:0];
	assign wr_do = wr_pend_ff;
	assign rd_do = rd_pend_ff;

	// ========================================================
	// registers
	logic [SRC_W-1:0] rise_en_ff;
	logic [SRC_W-1:0] fall_en_ff;
	logic [SRC_W-1:0] latch_ff;
	logic [SRC_W-1:0] irq_stat_ff;
	logic [SRC_W-1:0] irq_mask_ff;
	logic [SRC_W-1:0] nxt_rise_en;
	logic [SRC_W-1:0] nxt_fall_en;
	logic [SRC_W-1:0] nxt_latch;
	logic [SRC_W-1:0] nxt_irq_stat;
	logic [SRC_W-1:0] nxt_irq_mask;
	logic [SRC_W-1:0] evt;
	logic [SRC_W-1:0] rd_val;

	// unmasked change per source
	assign evt = (rise & rise_en_ff) | (fall & fall_en_ff);

	// read mux; reserved bits 7..5 and unmapped words read zero
	always_comb
	begin
		rd_val = 5'h00;
		unique case (idx_ff)
			IDX_RISE_WR, IDX_RISE_SET, IDX_RISE_CLR: rd_val = rise_en_ff;
			IDX_FALL_WR, IDX_FALL_SET, IDX_FALL_CLR: rd_val = fall_en_ff;
			IDX_LIVE:                                rd_val = src_now;
			IDX_LATCH:                               rd_val = latch_ff;
			IDX_IRQ_STAT:                            rd_val = irq_stat_ff;
			IDX_IRQ_MASK:                            rd_val = irq_mask_ff;
			default:                                 rd_val = 5'h00;
		endcase
	end

	always_comb
	begin
		nxt_wr_pend   = take & hwrite;
		nxt_rd_pend   = take & ~hwrite;
		nxt_idx       = take ? haddr[31:2] : idx_ff;
		nxt_hreadyout = ~(take & ~hwrite);
		nxt_hrdata    = hrdata_ff;
		if (rd_do)
		begin
			nxt_hrdata = {27'h0000000, rd_val};
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			wr_pend_ff   <= 1'b0;
			rd_pend_ff   <= 1'b0;
			idx_ff       <= 30'h00000000;
			hreadyout_ff <= 1'b1;
			hrdata_ff    <= 32'h00000000;
		end
		else
		begin
			wr_pend_ff   <= nxt_wr_pend;
			rd_pend_ff   <= nxt_rd_pend;
			idx_ff       <= nxt_idx;
			hreadyout_ff <= nxt_hreadyout;
			hrdata_ff    <= nxt_hrdata;
		end
	end

	// ========================================================
	// register updates
	always_comb
	begin
		nxt_rise_en  = rise_en_ff;
		nxt_fall_en  = fall_en_ff;
		nxt_irq_mask = irq_mask_ff;
		nxt_latch    = latch_ff;
		nxt_irq_stat = irq_stat_ff;
		if (wr_do)
		begin
			unique case (idx_ff)
				IDX_RISE_WR:  nxt_rise_en  = wbyte[SRC_W-1:0];
				IDX_RISE_SET: nxt_rise_en  = rise_en_ff | wbyte[SRC_W-1:0];
				IDX_RISE_CLR: nxt_rise_en  = rise_en_ff & ~wbyte[SRC_W-1:0];
				IDX_FALL_WR:  nxt_fall_en  = wbyte[SRC_W-1:0];
				IDX_FALL_SET: nxt_fall_en  = fall_en_ff | wbyte[SRC_W-1:0];
				IDX_FALL_CLR: nxt_fall_en  = fall_en_ff & ~wbyte[SRC_W-1:0];
				IDX_IRQ_STAT: nxt_irq_stat = irq_stat_ff & ~wbyte[SRC_W-1:0];
				IDX_IRQ_MASK: nxt_irq_mask = wbyte[SRC_W-1:0];
				// live and latch words ignore writes
				default:      nxt_rise_en  = rise_en_ff;
			endcase
		end
		// the whole latch word clears as it is returned, or on low power
		if ((rd_do && idx_ff == IDX_LATCH) || low_power_enter)
		begin
			nxt_latch = 5'h00;
		end
		// a new event in the clearing cycle is kept
		nxt_latch    = nxt_latch | evt;
		nxt_irq_stat = nxt_irq_stat | evt;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			rise_en_ff  <= RST_EDGE_EN;
			fall_en_ff  <= RST_EDGE_EN;
			latch_ff    <= RST_LATCH;
			irq_stat_ff <= RST_IRQ_STAT;
			irq_mask_ff <= RST_IRQ_MASK;
		end
		else
		begin
			rise_en_ff  <= nxt_rise_en;
			fall_en_ff  <= nxt_fall_en;
			latch_ff    <= nxt_latch;
			irq_stat_ff <= nxt_irq_stat;
			irq_mask_ff <= nxt_irq_mask;
		end
	end

	// ========================================================
	// rxcmd queue
	// one slot: later enabled edges merge into the waiting rxcmd with fresh
	// source values, so the link sees the state at the newest enabled edge
	// limitation: a link that stalls across several changes sees only
	// the final values, never the intermediate ones
	logic             rxv_ff;
	logic [SRC_W-1:0] rxd_ff;
	logic             nxt_rxv;
	logic [SRC_W-1:0] nxt_rxd;

	always_comb
	begin
		nxt_rxv = rxv_ff;
		nxt_rxd = rxd_ff;
		if (rxv_ff && rxcmd_ready)
		begin
			nxt_rxv = 1'b0;
		end
		// a fresh event wins over the hand-off in the same cycle
		if (|evt)
		begin
			nxt_rxv = 1'b1;
			nxt_rxd = src_now;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			rxv_ff <= 1'b0;
			rxd_ff <= 5'h00;
		end
		else
		begin
			rxv_ff <= nxt_rxv;
			rxd_ff <= nxt_rxd;
		end
	end

	// ========================================================
	// interrupt
	// built from the next status and mask, so irq follows a status or
	// mask change at the same edge rather than one cycle later
	logic irq_ff;
	logic nxt_irq;

	always_comb
	begin
		nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			irq_ff <= 1'b0;
		end
		else
		begin
			irq_ff <= nxt_irq;
		end
	end

	// ========================================================
	// bus response
	// no error is ever signalled, but the response still leaves a
	// flip-flop like every other output of the block
	logic hresp_ff;
	logic nxt_hresp;

	always_comb
	begin
		nxt_hresp = 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			hresp_ff <= 1'b0;
		end
		else
		begin
			hresp_ff <= nxt_hresp;
		end
	end

	// ========================================================
	// outputs
	assign hrdata      = hrdata_ff;
	assign hreadyout   = hreadyout_ff;
	assign hresp       = hresp_ff;
	assign rxcmd_valid = rxv_ff;
	assign rxcmd_data  = rxd_ff;
	assign irq         = irq_ff;

endmodule

`default_nettype wire

// file: bench/evt_props.sv
// checker for the event register block
`timescale 1ns/1ps
`default_nettype none
module evt_props
	import otg_evt_pkg::*;
(
	input wire logic        sys_clk,      // clock
	input wire logic        sys_rst,      // reset
	input wire logic        hsel,         // select
	input wire logic [31:0] haddr,        // address
	input wire logic [1:0]  htrans,       // transfer
	input wire logic        hwrite,       // write
	input wire logic        hready,       // bus ready
	input wire logic [31:0] hrdata,       // read data
	input wire logic        hreadyout,    // slave ready
	input wire logic        id_grounded,  // source
	input wire logic        session_over, // source
	input wire logic        session_ok,   // source
	input wire logic        bus_power_ok, // source
	input wire logic        host_detach,  // source
	input wire logic        rxcmd_valid,  // pending
	input wire logic [4:0]  rxcmd_data,   // payload
	input wire logic        rxcmd_ready   // link ready
);
	logic [4:0] sv;
	logic       tk;
	assign sv = {id_grounded, session_over, session_ok, bus_power_ok, host_detach};
	assign tk = hsel && hready && htrans[1];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// ==
	// bus
	rd_wait_a: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait wrong");
	wr_nowait_a: assert property (tk && hwrite |=> hreadyout)
		else $error("write stalled");
	live_read_a: assert property ((tk && !hwrite && haddr[31:2] == IDX_LIVE ##1 $stable(sv) [*2]) |-> hrdata[4:0] == sv)
		else $error("live value wrong");
	reserved_zero_a: assert property (hrdata[31:5] == 27'h0000000)
		else $error("reserved bits set");
	// ==
	// rxcmd
	rxcmd_hold_a: assert property (rxcmd_valid && !rxcmd_ready |=> rxcmd_valid)
		else $error("rxcmd dropped");
	rxcmd_data_a: assert property ($rose(rxcmd_valid) |-> rxcmd_data == $past(sv, 2))
		else $error("rxcmd payload wrong");
	edge_cause_a: assert property ($rose(rxcmd_valid) |-> $past(sv, 2) != $past(sv, 3))
		else $error("rxcmd without edge");
	rxcmd_done_a: assert property (rxcmd_valid && rxcmd_ready && $past(sv) == $past(sv, 2) |=> !rxcmd_valid)
		else $error("rxcmd not consumed");
	cover property (tk && !hwrite && haddr[31:2] == IDX_LATCH);
	cover property (rxcmd_valid && rxcmd_ready);
	cover property (rxcmd_valid && !rxcmd_ready);
endmodule
bind usb_otg_event_interrupt_regs evt_props chk (.sys_clk, .sys_rst, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hrdata, .hreadyout, .id_grounded, .session_over, .session_ok,
	.bus_power_ok, .host_detach, .rxcmd_valid, .rxcmd_data, .rxcmd_ready);
`default_nettype wire

// file: bench/link_model.sv
// link model that takes rxcmds and can stall
`timescale 1ns/1ps
`default_nettype none
module link_model
	import otg_evt_pkg::*;
(
	input  wire logic             sys_clk,     // clock
	input  wire logic             sys_rst,     // reset
	input  wire logic             stall,       // hold off
	input  wire logic             rxcmd_valid, // pending
	input  wire logic [SRC_W-1:0] rxcmd_data,  // payload
	output logic                  rxcmd_ready, // taking
	output logic      [SRC_W-1:0] last_data    // newest taken
);
	// ==
	// latch never read here: rxcmds carry the newest source values
	always_ff @(posedge sys_clk)
	begin
		rxcmd_ready <= !sys_rst && !stall;
		if (sys_rst)
			last_data <= 5'h00;
		else if (rxcmd_valid && rxcmd_ready)
			last_data <= rxcmd_data;
	end
endmodule
`default_nettype wire

// file: bench/testbench.sv
// bench for the event register block
`timescale 1ns/1ps
`default_nettype none
module testbench
	import otg_evt_pkg::*;
;
	logic        sys_clk, sys_rst, hsel, hwrite, lp, stall, rdy, irq, rxv, rxr;
	logic [1:0]  htrans;
	logic [29:0] b;
	logic [31:0] haddr, hwdata, hrdata;
	logic [4:0]  src, rxd, got;
	int          bad_count, cmp_count;
	usb_otg_event_interrupt_regs uut (.sys_clk, .sys_rst, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(rdy), .hrdata, .hreadyout(rdy),
		.hresp(), .id_grounded(src[4]), .session_over(src[3]), .session_ok(src[2]),
		.bus_power_ok(src[1]), .host_detach(src[0]), .low_power_enter(lp),
		.rxcmd_valid(rxv), .rxcmd_data(rxd), .rxcmd_ready(rxr), .irq);
	link_model lnk (.sys_clk, .sys_rst, .stall, .rxcmd_valid(rxv), .rxcmd_data(rxd),
		.rxcmd_ready(rxr), .last_data(got));
	// ==
	// helpers
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask
	// no cycle count assumed: the watchdog ends a hang
	task automatic bus(input logic w, input logic [29:0] i, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {i, 2'b00};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge sys_clk); while (rdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (rdy !== 1'b1);
	endtask
	task automatic rd(input logic [29:0] i, input logic [31:0] e);
		bus(1'b0, i, 32'h00000000);
		check(hrdata, e);
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial
	begin
		#200000;
		bad_count++;
		final_report();
	end
	// ==
	// tests
	initial
	begin
		{sys_rst, hsel, hwrite, lp, stall} = 5'h10;
		{htrans, haddr, hwdata, src} = 71'h0;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rd(IDX_RISE_WR, 32'h1F);
		rd(IDX_FALL_CLR, 32'h1F);
		rd(IDX_LATCH, 32'h00);
		rd(30'h1F, 32'h00);
		$display("reset test done");
		for (int k = 0; k < 2; k++)
		begin
			b = k ? IDX_FALL_WR : IDX_RISE_WR;
			bus(1'b1, b, 32'h0A);
			rd(b + 30'h1, 32'h0A);
			bus(1'b1, b + 30'h1, 32'h11);
			rd(b + 30'h2, 32'h1B);
			bus(1'b1, b + 30'h2, 32'h03);
			rd(b, 32'h18);
			bus(1'b1, b, 32'hFF);
			rd(b, 32'h1F);
		end
		src <= 5'h15;
		rd(IDX_LIVE, 32'h15);
		$display("register test done");
		for (int i = 0; i < 5; i++)
		begin
			bus(1'b1, IDX_RISE_WR, 32'h1 << i);
			bus(1'b1, IDX_FALL_WR, 32'h00);
			src <= 5'h00;
			repeat (3) @(posedge sys_clk);
			bus(1'b0, IDX_LATCH, 32'h0);
			src <= 5'h1F;
			repeat (3) @(posedge sys_clk);
			rd(IDX_LATCH, 32'h1 << i);
			rd(IDX_LATCH, 32'h00);
			bus(1'b1, IDX_RISE_WR, 32'h00);
			bus(1'b1, IDX_FALL_WR, 32'h1 << i);
			src <= 5'h00;
			repeat (3) @(posedge sys_clk);
			rd(IDX_LATCH, 32'h1 << i);
		end
		bus(1'b1, IDX_IRQ_STAT, 32'h1F);
		bus(1'b1, IDX_RISE_WR, 32'h1F);
		bus(1'b1, IDX_IRQ_MASK, 32'h01);
		src <= 5'h01;
		repeat (3) @(posedge sys_clk);
		check(irq, 1'b1);
		bus(1'b1, IDX_IRQ_MASK, 32'h00);
		repeat (2) @(posedge sys_clk);
		check(irq, 1'b0);
		bus(1'b1, IDX_IRQ_STAT, 32'h01);
		rd(IDX_IRQ_STAT, 32'h00);
		lp <= 1'b1;
		@(posedge sys_clk);
		lp <= 1'b0;
		rd(IDX_LATCH, 32'h00);
		$display("event test done");
		stall <= 1'b1;
		repeat (2) @(posedge sys_clk);
		src <= 5'h03;
		repeat (3) @(posedge sys_clk);
		check(rxv, 1'b1);
		check(rxd, 5'h03);
		src <= 5'h13;
		repeat (3) @(posedge sys_clk);
		check(rxd, 5'h13);
		stall <= 1'b0;
		repeat (4) @(posedge sys_clk);
		check(rxv, 1'b0);
		check(got, 5'h13);
		$display("rxcmd test done");
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		check(rxv, 1'b0);
		rd(IDX_LATCH, 32'h00);
		rd(IDX_RISE_WR, 32'h1F);
		$display("second reset test done");
		final_report();
	end
endmodule
`default_nettype wire
